/* File: rtl/tmwd_edge_det.sv */
// Input pin conditioner: sample, optional noise filter, edge pulses
`timescale 1ns/1ps
`default_nettype none
module tmwd_edge_det #(
  parameter int NF_LEN = tmwd_pkg::NF_SAMPLES
) (
  input  wire logic   core_clk,
  input  wire logic   rst_b,
  input  wire logic   unit_en,
  input  wire logic   nf_en,
  input  wire logic   pin_in,
  tmwd_edge_if.src    ev
);
  localparam logic [tmwd_pkg::NF_CW-1:0] LAST = tmwd_pkg::NF_CW'(NF_LEN - 1);
  localparam logic [tmwd_pkg::NF_CW-1:0] ONE  = tmwd_pkg::NF_CW'(1);

  logic                      pin_r;
  logic                      lvl_r;
  logic                      rise_r;
  logic                      fall_r;
  logic [tmwd_pkg::NF_CW-1:0] run_r;

  // A new level is accepted at once, or after NF_LEN equal samples when filtered
  wire differ = pin_r ^ lvl_r;
  wire settle = differ & (~nf_en | (run_r == LAST));

  // Cleared with the unit so a stopped unit holds no stale edge
  always_ff @(posedge core_clk) begin
    if (!rst_b || !unit_en) begin
      pin_r  <= 1'b0;
      lvl_r  <= 1'b0;
      rise_r <= 1'b0;
      fall_r <= 1'b0;
      run_r  <= '0;
    end else begin
      pin_r  <= pin_in;
      run_r  <= (differ & ~settle) ? run_r + ONE : '0;
      lvl_r  <= lvl_r ^ settle;
      rise_r <= settle & ~lvl_r;
      fall_r <= settle & lvl_r;
    end
  end

  assign ev.rise = rise_r;
  assign ev.fall = fall_r;
endmodule
`default_nettype wire

/* File: rtl/tmwd_edge_if.sv */
// Edge events passed from the input conditioner to the channel core
`timescale 1ns/1ps
`default_nettype none
interface tmwd_edge_if;
  logic rise;
  logic fall;
  modport src (output rise, output fall);
  modport dst (input rise, input fall);
endinterface
`default_nettype wire

/* File: rtl/tmwd_pkg.sv */
// Shared constants and types for the timer width-measure / delay-count channel
package tmwd_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MODE = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_CNT  = 8'h0c;
  localparam logic [7:0] ADDR_DATA = 8'h10;

  // Control register bit positions
  localparam int CTRL_START = 0;
  localparam int CTRL_STOP  = 1;
  localparam int CTRL_UEN   = 2;
  localparam int CTRL_NFEN  = 3;

  // Mode register bit positions and prescaler field
  localparam int MODE_DLY  = 0;
  localparam int MODE_CISL = 1;
  localparam int MODE_CISH = 2;
  localparam int MODE_DIV  = 8;
  localparam int DIV_W     = 8;

  // Status register bit positions
  localparam int STAT_OVF = 0;
  localparam int STAT_EN  = 1;

  // Counter width and noise filter depth
  localparam int CNT_W      = 16;
  localparam int NF_SAMPLES = 3;
  localparam int NF_CW      = 4;

  // Channel sequencing
  typedef enum logic [1:0] {ST_STOP, ST_WAIT, ST_RUN} tmwd_state_t;
endpackage

/* File: rtl/tmwd_timer_chan.sv */
// Timer channel: input pulse-width measurement and delay counter, APB slave
// Function
// - start trigger bit clears itself after write
// - width start sets enable, waits start edge
// - start edge clears count, counts up
// - capture edge copies count, raises interrupt
// - capture sets or clears overflow flag
// - count halts after capture until start edge
// - count readable, data rewritable while running
// - stop self-clears, clears enable, holds count
// - stop in width mode keeps overflow flag
// - unit enable low reinitialises whole channel
// - delay start sets enable, waits active edge
// - active edge loads data, counts down
// - start write while enabled also starts count
// - zero count raises interrupt and halts
// - delay equals count period times data plus one
// - data rewrite applies from next count cycle
// - multiple wraps still set overflow flag
`timescale 1ns/1ps
`default_nettype none
module tmwd_timer_chan #(
  parameter int CNT_W = tmwd_pkg::CNT_W,
  parameter int DIV_W = tmwd_pkg::DIV_W
) (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        timer_in,
  output logic             channel_interrupt
);
  localparam logic [CNT_W-1:0] ONE  = CNT_W'(1);
  localparam logic [CNT_W-1:0] CMAX = '1;
  localparam logic [DIV_W-1:0] DONE = DIV_W'(1);

  logic                 pready_r;
  logic                 pslverr_r;
  logic [31:0]          prdata_r;
  logic                 unit_en_r;
  logic                 nf_en_r;
  logic                 mode_dly_r;
  logic                 cis_l_r;
  logic                 cis_h_r;
  logic [DIV_W-1:0]     div_r;
  logic [DIV_W-1:0]     presc_r;
  logic [CNT_W-1:0]     cnt_r;
  logic [CNT_W-1:0]     cnt_nxt;
  logic [CNT_W-1:0]     data_r;
  logic [CNT_W-1:0]     data_nxt;
  logic                 ovf_r;
  logic                 ovf_nxt;
  logic                 pend_r;
  logic                 pend_nxt;
  logic                 en_r;
  logic                 en_nxt;
  logic                 irq_r;
  logic                 irq_nxt;
  tmwd_pkg::tmwd_state_t st_r;
  tmwd_pkg::tmwd_state_t st_nxt;

  tmwd_edge_if ev_if ();

  tmwd_edge_det u_edge (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .unit_en  (unit_en_r),
    .nf_en    (nf_en_r),
    .pin_in   (timer_in),
    .ev       (ev_if.src)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB decode: one wait state, writes land on the edge that samples pready
  wire acc      = psel & penable;
  wire acc_done = acc & pready_r;
  wire wr_en    = acc_done & pwrite;
  wire sel_ctrl = paddr == tmwd_pkg::ADDR_CTRL;
  wire sel_mode = paddr == tmwd_pkg::ADDR_MODE;
  wire sel_stat = paddr == tmwd_pkg::ADDR_STAT;
  wire sel_cnt  = paddr == tmwd_pkg::ADDR_CNT;
  wire sel_data = paddr == tmwd_pkg::ADDR_DATA;
  wire hit      = sel_ctrl | sel_mode | sel_stat | sel_cnt | sel_data;
  wire wr_ctrl  = wr_en & sel_ctrl;
  // Mode and data cannot be written while the unit clock is off
  wire wr_mode  = wr_en & sel_mode & unit_en_r;
  wire wr_data  = wr_en & sel_data & unit_en_r;
  wire start_wr = wr_ctrl & unit_en_r & pwdata[tmwd_pkg::CTRL_START];
  wire stop_wr  = wr_ctrl & unit_en_r & pwdata[tmwd_pkg::CTRL_STOP];

  // Read mux; trigger bits are not stored and always read zero
  wire [31:0] rd_ctrl = 32'(unit_en_r) << tmwd_pkg::CTRL_UEN
                      | 32'(nf_en_r) << tmwd_pkg::CTRL_NFEN;
  wire [31:0] rd_mode = 32'(mode_dly_r) << tmwd_pkg::MODE_DLY
                      | 32'(cis_l_r) << tmwd_pkg::MODE_CISL
                      | 32'(cis_h_r) << tmwd_pkg::MODE_CISH
                      | 32'(div_r) << tmwd_pkg::MODE_DIV;
  wire [31:0] rd_stat = 32'(ovf_r) << tmwd_pkg::STAT_OVF
                      | 32'(en_r) << tmwd_pkg::STAT_EN;
  wire [31:0] rd_val  = sel_ctrl ? rd_ctrl :
                        sel_mode ? rd_mode :
                        sel_stat ? rd_stat :
                        sel_cnt  ? 32'(cnt_r) :
                        sel_data ? 32'(data_r) : 32'h0000_0000;

  // Bus answer flops
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= acc & ~pready_r;
      pslverr_r <= acc & ~pready_r & ~hit;
      if (acc & ~pready_r & ~pwrite) begin
        prdata_r <= rd_val;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration; clearing the unit enable wipes every channel setting
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      unit_en_r <= 1'b0;
    end else if (wr_ctrl) begin
      unit_en_r <= pwdata[tmwd_pkg::CTRL_UEN];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b || !unit_en_r) begin
      nf_en_r    <= 1'b0;
      mode_dly_r <= 1'b0;
      cis_l_r    <= 1'b0;
      cis_h_r    <= 1'b0;
      div_r      <= '0;
    end else begin
      if (wr_ctrl) begin
        nf_en_r <= pwdata[tmwd_pkg::CTRL_NFEN];
      end
      if (wr_mode) begin
        mode_dly_r <= pwdata[tmwd_pkg::MODE_DLY];
        cis_l_r    <= pwdata[tmwd_pkg::MODE_CISL];
        cis_h_r    <= pwdata[tmwd_pkg::MODE_CISH];
        div_r      <= pwdata[tmwd_pkg::MODE_DIV +: DIV_W];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge roles: high width starts on rise, low width on fall
  wire start_edge = cis_l_r ? ev_if.rise : ev_if.fall;
  wire cap_edge   = cis_l_r ? ev_if.fall : ev_if.rise;
  wire dly_edge   = cis_h_r ? (ev_if.rise | ev_if.fall)
                  : (cis_l_r ? ev_if.rise : ev_if.fall);

  wire in_wait = st_r == tmwd_pkg::ST_WAIT;
  wire in_run  = st_r == tmwd_pkg::ST_RUN;
  // Start from the stopped state only; a width-mode restart while enabled is ignored
  wire go      = start_wr & ~en_r;
  wire w_start = ~mode_dly_r & in_wait & start_edge;
  wire w_cap   = ~mode_dly_r & in_run & cap_edge;
  wire d_trig  = mode_dly_r & en_r & (dly_edge | start_wr);
  wire tick    = presc_r == div_r;
  wire run_tk  = in_run & tick;

  // Count clock prescaler, realigned at every count start so delays are exact
  wire [DIV_W-1:0] presc_nxt = (w_start | d_trig | tick) ? '0 : presc_r + DONE;

  ////////////////////////////////////////////////////////////////////////////
  // Channel sequencing; capture outranks a same-cycle software data write
  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    en_nxt   = en_r;
    ovf_nxt  = ovf_r;
    pend_nxt = pend_r;
    data_nxt = wr_data ? pwdata[CNT_W-1:0] : data_r;
    irq_nxt  = 1'b0;
    if (!unit_en_r) begin
      st_nxt   = tmwd_pkg::ST_STOP;
      cnt_nxt  = '0;
      en_nxt   = 1'b0;
      ovf_nxt  = 1'b0;
      pend_nxt = 1'b0;
      data_nxt = '0;
    end else if (stop_wr) begin
      st_nxt = tmwd_pkg::ST_STOP;
      en_nxt = 1'b0;
    end else if (go) begin
      st_nxt = tmwd_pkg::ST_WAIT;
      en_nxt = 1'b1;
    end else if (w_start) begin
      st_nxt   = tmwd_pkg::ST_RUN;
      cnt_nxt  = '0;
      pend_nxt = 1'b0;
    end else if (w_cap) begin
      st_nxt   = tmwd_pkg::ST_WAIT;
      data_nxt = cnt_r;
      irq_nxt  = 1'b1;
      ovf_nxt  = pend_r;
      cnt_nxt  = cnt_r + ONE;
    end else if (d_trig) begin
      st_nxt  = tmwd_pkg::ST_RUN;
      cnt_nxt = data_r;
    end else if (run_tk) begin
      if (!mode_dly_r) begin
        cnt_nxt = cnt_r + ONE;
        // Sticky across any number of wraps
        if (cnt_r == CMAX) begin
          pend_nxt = 1'b1;
        end
      end else if (cnt_r == '0) begin
        st_nxt  = tmwd_pkg::ST_WAIT;
        irq_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r - ONE;
      end
    end
  end

  // State flops
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      st_r    <= tmwd_pkg::ST_STOP;
      cnt_r   <= '0;
      data_r  <= '0;
      en_r    <= 1'b0;
      ovf_r   <= 1'b0;
      pend_r  <= 1'b0;
      irq_r   <= 1'b0;
      presc_r <= '0;
    end else begin
      st_r    <= st_nxt;
      cnt_r   <= cnt_nxt;
      data_r  <= data_nxt;
      en_r    <= en_nxt;
      ovf_r   <= ovf_nxt;
      pend_r  <= pend_nxt;
      irq_r   <= irq_nxt;
      presc_r <= presc_nxt;
    end
  end

  assign prdata            = prdata_r;
  assign pready            = pready_r;
  assign pslverr           = pslverr_r;
  assign channel_interrupt = irq_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  sequence s_go;
    go && !stop_wr;
  endsequence
  sequence s_cap;
    unit_en_r && !stop_wr && !go && w_cap;
  endsequence
  sequence s_dtrig;
    unit_en_r && !stop_wr && !go && d_trig;
  endsequence

  start_enable_a: assert property (s_go |=> en_r && in_wait)
    else $error("start did not enable channel");
  start_clear_a: assert property (unit_en_r && !stop_wr && !go && w_start
    |=> cnt_r == '0 && in_run)
    else $error("start edge did not clear count");
  capture_copy_a: assert property (s_cap
    |=> data_r == $past(cnt_r) && channel_interrupt && in_wait)
    else $error("capture did not copy count");
  capture_ovf_a: assert property (s_cap |=> ovf_r == $past(pend_r))
    else $error("overflow flag not updated at capture");
  stop_hold_a: assert property (stop_wr && unit_en_r
    |=> !en_r && cnt_r == $past(cnt_r) && ovf_r == $past(ovf_r))
    else $error("stop did not halt and hold");
  stopped_frozen_a: assert property (st_r == tmwd_pkg::ST_STOP && $stable(st_r)
    |-> $stable(cnt_r) || !unit_en_r || !$past(unit_en_r))
    else $error("count moved while stopped");
  unit_init_a: assert property (!unit_en_r
    |=> cnt_r == '0 && !en_r && !ovf_r && st_r == tmwd_pkg::ST_STOP)
    else $error("unit disable did not reinitialise");
  delay_load_a: assert property (s_dtrig |=> in_run && cnt_r == $past(data_r))
    else $error("delay trigger did not load data");
  delay_zero_a: assert property (unit_en_r && !stop_wr && !go && !d_trig
    && mode_dly_r && run_tk && cnt_r == '0 |=> channel_interrupt && in_wait)
    else $error("zero count did not interrupt");
  wrap_flag_a: assert property (unit_en_r && !stop_wr && !go && !w_start && !w_cap
    && !mode_dly_r && run_tk && cnt_r == CMAX |=> pend_r && cnt_r == '0)
    else $error("wrap not recorded");
  irq_pulse_a: assert property (channel_interrupt |=> !channel_interrupt)
    else $error("interrupt longer than one cycle");
endmodule
`default_nettype wire

/* File: test/timer_width_measure_delay_count_tb_top.sv */
// Testbench: width measurement and delay counter channel driven over APB
`timescale 1ns/1ps
`default_nettype none
module timer_width_measure_delay_count_tb_top;
  localparam logic [7:0] A_CTRL = tmwd_pkg::ADDR_CTRL;
  localparam logic [7:0] A_MODE = tmwd_pkg::ADDR_MODE;
  localparam logic [7:0] A_STAT = tmwd_pkg::ADDR_STAT;
  localparam logic [7:0] A_CNT  = tmwd_pkg::ADDR_CNT;
  localparam logic [7:0] A_DATA = tmwd_pkg::ADDR_DATA;
  logic        core_clk = 1'b0;
  logic        rst_b;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        timer_in;
  logic        channel_interrupt;
  logic [31:0] rd;
  logic [31:0] d1;
  logic        er;
  int          err_count = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          irq_n = 0;
  int          irq_cyc = 0;
  int          t_acc, ts, n0, w, dv, i;
  int          dat[2];
  int          del[2];

  tmwd_timer_chan u_tmwd_timer_chan (.core_clk(core_clk), .rst_b(rst_b), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer_in(timer_in),
    .channel_interrupt(channel_interrupt));
  tmwd_pulse_src u_tmwd_pulse_src (.core_clk(core_clk), .pin(timer_in));

  // 200 MHz core clock
  always #2.5 core_clk = ~core_clk;

  // Cycle counter and interrupt pulse monitor; the pulse lasts one cycle
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (channel_interrupt === 1'b1) begin
      irq_n   <= irq_n + 1;
      irq_cyc <= cyc;
    end
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; the wait on pready is bounded so a dead slave ends the run
  task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= wr;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (pready !== 1'b1) begin
      err_count++;
      tally_and_finish();
    end
    rd      = prdata;
    er      = pslverr;
    t_acc   = cyc;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(a, 1'b0, 32'h0);
    chk(what, exp, rd);
  endtask

  task automatic wait_irq(input int base, input int bound);
    int n;
    n = 0;
    while (irq_n == base && n < bound) begin
      @(posedge core_clk);
      n++;
    end
    if (irq_n == base) begin
      err_count++;
      $display("BAD interrupt expected 1 seen 0");
      tally_and_finish();
    end
  endtask

  // One pulse of the active level, then the capture result is read from DATA
  task automatic meas(input logic act, input int width);
    u_tmwd_pulse_src.hold(!act, 8);
    n0 = irq_n;
    u_tmwd_pulse_src.hold(act, width);
    u_tmwd_pulse_src.hold(!act, 8);
    wait_irq(n0, 64);
    chk("irq_count", 32'(n0 + 1), 32'(irq_n));
    apb(A_DATA, 1'b0, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_b = 1'b0; paddr = 8'h00; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    pwdata = 32'h0;
    void'($urandom(75048));
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    // Reset state, then an unmapped address must be refused
    rdchk(A_STAT, 32'h0, "stat_reset");
    apb(8'h14, 1'b0, 32'h0);
    chk("slverr", 32'h1, 32'(er));
    chk("unmapped_read", 32'h0, rd);
    // High width; output enable does not exist here, so nothing to clear
    wr_seq();
    w = 20 + $urandom_range(180);
    meas(1'b1, w);
    d1 = rd;
    chk("width_hi", 32'h1, 32'(rd + 2 >= w && rd <= w + 1));
    rdchk(A_STAT, 32'h2, "ovf_clear");
    // Long pulse wraps the 16-bit count; the difference stays exact
    meas(1'b1, 70000);
    chk("width_wrap", 32'((70000 - w) & 16'hffff), (rd - d1) & 32'hffff);
    rdchk(A_STAT, 32'h3, "ovf_set");
    // Stop in mid-count keeps overflow and holds the count
    u_tmwd_pulse_src.hold(1'b0, 8);
    u_tmwd_pulse_src.hold(1'b1, 40);
    n0 = irq_n;
    apb(A_CTRL, 1'b1, 32'h6);
    rdchk(A_STAT, 32'h1, "stop_status");
    rdchk(A_CTRL, 32'h4, "stop_selfclear");
    apb(A_CNT, 1'b0, 32'h0);
    d1 = rd;
    rdchk(A_CNT, d1, "count_held");
    u_tmwd_pulse_src.hold(1'b0, 20);
    chk("no_irq_stopped", 32'(n0), 32'(irq_n));
    // Low width (select 10) after a legal mode change while stopped, noise filter on
    apb(A_MODE, 1'b1, 32'h4);
    apb(A_CTRL, 1'b1, 32'hd);
    w = 10 + $urandom_range(90);
    meas(1'b0, w);
    chk("width_lo", 32'h1, 32'(rd + 2 >= w && rd <= w + 1));
    rdchk(A_STAT, 32'h2, "ovf_recleared");
    // A two-cycle glitch is shorter than the filter, so it starts nothing
    n0 = irq_n;
    u_tmwd_pulse_src.hold(1'b0, 2);
    u_tmwd_pulse_src.hold(1'b1, 16);
    chk("filter_glitch", 32'(n0), 32'(irq_n));
    apb(A_CTRL, 1'b1, 32'h6);
    // Delay mode on falling edges with a random prescaler
    dv = $urandom_range(3);
    apb(A_MODE, 1'b1, 32'(1 + (dv << 8)));
    n0 = irq_n;
    apb(A_CTRL, 1'b1, 32'h5);
    rdchk(A_STAT, 32'h2, "delay_enable");
    chk("delay_waits", 32'(n0), 32'(irq_n));
    for (i = 0; i < 2; i++) begin
      dat[i] = 3 + $urandom_range(40);
      apb(A_DATA, 1'b1, 32'(dat[i]));
      n0 = irq_n;
      apb(A_CTRL, 1'b1, 32'h5);
      wait_irq(n0, 2000);
      del[i] = irq_cyc - t_acc;
      w = (dat[i] + 1) * (dv + 1);
      chk("delay_abs", 32'h1, 32'(del[i] >= w - 1 && del[i] <= w + 4));
      rdchk(A_CNT, 32'h0, "count_zero");
    end
    chk("delay_diff", 32'((dat[1] - dat[0]) * (dv + 1)), 32'(del[1] - del[0]));
    // A data rewrite mid-count must not shorten the count in progress
    apb(A_DATA, 1'b1, 32'd200);
    n0 = irq_n;
    apb(A_CTRL, 1'b1, 32'h5);
    ts = t_acc;
    apb(A_DATA, 1'b1, 32'h5);
    wait_irq(n0, 3000);
    chk("delay_rewrite", 32'h1, 32'(irq_cyc - ts >= 201 * (dv + 1) - 1));
    // Pin edge trigger, then a single interrupt only
    n0 = irq_n;
    u_tmwd_pulse_src.hold(1'b1, 8);
    u_tmwd_pulse_src.hold(1'b0, 8);
    wait_irq(n0, 3000);
    repeat (300) @(posedge core_clk);
    chk("single_irq", 32'(n0 + 1), 32'(irq_n));
    // Both-edge delay mode: a rising pin edge must start the count too
    apb(A_CTRL, 1'b1, 32'h6);
    apb(A_MODE, 1'b1, 32'(5 + (dv << 8)));
    apb(A_CTRL, 1'b1, 32'h5);
    n0 = irq_n;
    u_tmwd_pulse_src.hold(1'b1, 8);
    wait_irq(n0, 3000);
    chk("both_edge_irq", 32'(n0 + 1), 32'(irq_n));
    // Unit disable reinitialises every register
    apb(A_CTRL, 1'b1, 32'h0);
    rdchk(A_MODE, 32'h0, "mode_init");
    rdchk(A_DATA, 32'h0, "data_init");
    rdchk(A_STAT, 32'h0, "stat_init");
    tally_and_finish();
  end

  // Unit on, high-width mode, start; start must read back as zero
  task automatic wr_seq();
    apb(A_CTRL, 1'b1, 32'h4);
    apb(A_MODE, 1'b1, 32'h6);
    apb(A_CTRL, 1'b1, 32'h5);
    rdchk(A_CTRL, 32'h4, "start_selfclear");
    rdchk(A_STAT, 32'h2, "width_enable");
  endtask
endmodule
`default_nettype wire

/* File: test/tmwd_pulse_src.sv */
// Partner model: external digital pulse source on the timer input pin
`timescale 1ns/1ps
`default_nettype none
module tmwd_pulse_src (
  input  wire logic core_clk,
  output logic      pin
);
  // Push-pull source, so the pin always has a defined level; idles low
  initial pin = 1'b0;

  // Hold one level for a number of core clocks; called just after a rising edge
  task automatic hold(input logic lvl, input int cycles);
    pin <= lvl;
    repeat (cycles) @(posedge core_clk);
  endtask
endmodule
`default_nettype wire
